// ### shared/ysq_pkg.sv
package ysq_pkg;

   // Clock and Y-count step timing.
   localparam int CLK_PERIOD_NS   = 8;
   localparam int YCLK_PERIOD_NS  = 50;
   localparam int YCLK_DIV_CYCLES = YCLK_PERIOD_NS / CLK_PERIOD_NS;

   // Y counter geometry.
   localparam int          Y_WIDTH = 9;
   localparam logic [8:0]  Y_ZERO  = 9'h000;
   localparam logic [8:0]  Y_ONE   = 9'h001;

   // Match ROM geometry.
   localparam int ROM_ADDR_W = 5;
   localparam int ROM_DATA_W = 8;
   localparam int ROM_QUADS  = 4;
   localparam int ROM_QUAD_N = 8;
   localparam int ROM_POINTS = 4;
   localparam int ROM_FIRST  = 4;

   // Match points per quadrant, index [quadrant][point].
   localparam logic [7:0] MATCH_VALS [ROM_QUADS][ROM_POINTS] = '{
      '{8'hFE, 8'h1B, 8'h37, 8'h4F},
      '{8'h7E, 8'h1B, 8'h37, 8'h4F},
      '{8'hFE, 8'h0B, 8'h17, 8'h2F},
      '{8'h7E, 8'h0B, 8'h17, 8'h2F}
   };

   // APB register offsets.
   localparam logic [11:0] CTRL_OFS   = 12'h000;
   localparam logic [11:0] STATUS_OFS = 12'h004;
   localparam logic [11:0] MATCH_OFS  = 12'h008;

   // Control register fields and reset value.
   localparam int          CTRL_RUN_BIT      = 0;
   localparam int          CTRL_COMPRESS_BIT = 1;
   localparam int          CTRL_625_BIT      = 2;
   localparam int          CTRL_W            = 3;
   localparam logic [2:0]  CTRL_RESET        = 3'h1;

   // Status register fields.
   localparam int ST_STATE_LSB = 0;
   localparam int ST_GATE_BIT  = 4;
   localparam int ST_CDB_BIT   = 5;
   localparam int ST_SB_BIT    = 6;
   localparam int ST_CLEAR_BIT = 7;
   localparam int ST_SWAP_BIT  = 8;
   localparam int ST_QUAL_BIT  = 9;
   localparam int ST_XCLK_BIT  = 10;
   localparam int ST_Y_LSB     = 16;

   // Output levels after reset.
   localparam logic BLANK_RESET = 1'b1;
   localparam logic XCLK_RESET  = 1'b1;

   // Sequencer states, one-hot.
   typedef enum logic [15:0] {
      st_arm          = 16'h0001,
      st_swap         = 16'h0002,
      st_fill2        = 16'h0004,
      st_fill3        = 16'h0008,
      st_fill4        = 16'h0010,
      st_fill5        = 16'h0020,
      st_fill6        = 16'h0040,
      st_fill7        = 16'h0080,
      st_fill8        = 16'h0100,
      st_wait_lower   = 16'h0200,
      st_wrap         = 16'h0400,
      st_wait_retrace = 16'h0800,
      st_fall12       = 16'h1000,
      st_wait_scan    = 16'h2000,
      st_fall14       = 16'h4000,
      st_wait_end     = 16'h8000
   } seq_state_e;

endpackage

// ### shared/rom_if.sv
`timescale 1ns/1ps
// Address and data of the match ROM.
interface rom_if;
   import ysq_pkg::*;
   logic [ROM_ADDR_W-1:0] addr;
   logic [ROM_DATA_W-1:0] data;
   modport user (output addr, input data);
   modport rom  (input addr, output data);
endinterface

// ### hw/y_match_rom.sv
`timescale 1ns/1ps
module y_match_rom
   import ysq_pkg::*;
(
   input  wire logic clk,
   input  wire logic rstn,
   rom_if.rom        port
);

   logic [ROM_DATA_W-1:0] mem  [ROM_QUADS*ROM_QUAD_N];
   logic [ROM_DATA_W-1:0] data_r;
   logic [ROM_DATA_W-1:0] data_nxt;

   // Each quadrant holds its four match points in its top entries; lower entries are zero.
   for (genvar q = 0; q < ROM_QUADS; q++)
   begin : g_quad
      for (genvar e = 0; e < ROM_QUAD_N; e++)
      begin : g_entry
         if (e >= ROM_FIRST)
         begin : g_point
            assign mem[q*ROM_QUAD_N+e] = MATCH_VALS[q][e-ROM_FIRST];
         end
         else
         begin : g_blank
            assign mem[q*ROM_QUAD_N+e] = 8'h00;
         end
      end
   end

   // Read lookup.
   always_comb
   begin
      data_nxt = mem[port.addr];
   end

   // Registered read port.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         data_r <= 8'h00;
      else
         data_r <= data_nxt;
   end

   assign port.data = data_r;

endmodule // y_match_rom

// ### hw/y_ramp_sequencer.sv
`timescale 1ns/1ps
module y_ramp_sequencer
   import ysq_pkg::*;
#(
   parameter int YCLK_DIV = YCLK_DIV_CYCLES
)
(
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        x_blanking_enable,
   output logic             x_blanking_drive,
   output logic             y_count_enable_a,
   output logic      [8:0]  y_count,
   output logic             y_ramp_gate,
   output logic             y_count_clear,
   output logic             cache_swap_pulse,
   output logic             x_count_clock,
   output logic             composite_buffer_blank,
   output logic             storage_blank,
   output logic             qualifier_test
);

   // Refuse divider settings the counter cannot serve.
   if (YCLK_DIV < 2 || YCLK_DIV > 256)
   begin : g_bad_div
      $error("YCLK_DIV must lie between 2 and 256");
   end

   // Tells whether a state compares the Y count against the ROM.
   function automatic logic is_test_state(input seq_state_e s);
      return (s == st_wait_lower) || (s == st_wait_retrace) ||
             (s == st_wait_scan) || (s == st_wait_end);
   endfunction

   // Binary index of a one-hot state.
   function automatic logic [3:0] state_index(input seq_state_e s);
      logic [3:0] idx;
      idx = 4'h0;
      for (int i = 0; i < 16; i++)
      begin
         if (s[i])
            idx = 4'(i);
      end
      return idx;
   endfunction

   // Successor of each state in the 16-state ring.
   function automatic seq_state_e step_of(input seq_state_e s);
      seq_state_e n;
      n = st_arm;
      unique case (s)
         st_arm:          n = st_swap;
         st_swap:         n = st_fill2;
         st_fill2:        n = st_fill3;
         st_fill3:        n = st_fill4;
         st_fill4:        n = st_fill5;
         st_fill5:        n = st_fill6;
         st_fill6:        n = st_fill7;
         st_fill7:        n = st_fill8;
         st_fill8:        n = st_wait_lower;
         st_wait_lower:   n = st_wrap;
         st_wrap:         n = st_wait_retrace;
         st_wait_retrace: n = st_fall12;
         st_fall12:       n = st_wait_scan;
         st_wait_scan:    n = st_fall14;
         st_fall14:       n = st_wait_end;
         st_wait_end:     n = st_arm;
         default:         n = st_arm;
      endcase
      return n;
   endfunction

   localparam logic [7:0] DIV_LAST = 8'(YCLK_DIV - 1);

   logic [CTRL_W-1:0] ctrl_r;
   logic [CTRL_W-1:0] ctrl_nxt;
   logic [31:0]       prdata_r;
   logic [31:0]       prdata_nxt;
   logic              pready_r;
   logic              pready_nxt;
   logic              pslverr_r;
   logic              pslverr_nxt;
   logic [7:0]        div_r;
   logic [7:0]        div_nxt;
   logic              stb_r;
   logic              stb_nxt;
   seq_state_e        state_r;
   seq_state_e        state_nxt;
   logic [8:0]        y_r;
   logic [8:0]        y_nxt;
   logic              gate_r;
   logic              gate_nxt;
   logic              clear_r;
   logic              clear_nxt;
   logic              swap_r;
   logic              swap_nxt;
   logic              xclk_r;
   logic              xclk_nxt;
   logic              cdb_r;
   logic              cdb_nxt;
   logic              sb_r;
   logic              sb_nxt;
   logic              qual_r;
   logic              qual_nxt;
   logic              xdrv_r;
   logic              xdrv_nxt;
   logic [8:0]        match_val;
   logic              match;
   logic              advance;
   logic              exb_eff;
   logic              setup;
   logic              mapped;
   logic [31:0]       rd_mux;
   logic [1:0]        quad;
   logic [3:0]        state_idx;

   rom_if rom_bus ();

   y_match_rom u_rom
   (
      .clk  (clk),
      .rstn (rstn),
      .port (rom_bus.rom)
   );

   // Option selections form the two upper ROM address bits; standard is quadrant 10.
   assign quad         = {~ctrl_r[CTRL_625_BIT], ctrl_r[CTRL_COMPRESS_BIT]};
   assign state_idx    = state_index(state_r);
   assign rom_bus.addr = {quad, state_idx[3:1]};

   // ROM bit 4 is doubled onto comparator bits 4 and 5 to reach 510.
   assign match_val = {rom_bus.data[7:5], rom_bus.data[4], rom_bus.data[4:0]};

   // Comparators only act in test states; elsewhere each enable steps.
   assign match   = is_test_state(state_r) && (y_r == match_val);
   assign advance = stb_r && (!is_test_state(state_r) || match);

   // X blanking seen by the latches is the OR of our own drive and the X sequencer's.
   assign exb_eff = x_blanking_enable | xdrv_r;

   // Y-count enable divider: one pulse every YCLK_DIV clocks (48 ns by default) while running.
   always_comb
   begin
      div_nxt = div_r;
      stb_nxt = 1'b0;
      if (ctrl_r[CTRL_RUN_BIT])
      begin
         if (div_r == DIV_LAST)
         begin
            div_nxt = 8'h00;
            stb_nxt = 1'b1;
         end
         else
         begin
            div_nxt = div_r + 8'h01;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         div_r <= 8'h00;
         stb_r <= 1'b0;
      end
      else
      begin
         div_r <= div_nxt;
         stb_r <= stb_nxt;
      end
   end

   // Sequencer, Y counter and output latches, all stepped by the Y-count enable.
   always_comb
   begin
      state_nxt = state_r;
      y_nxt     = y_r;
      gate_nxt  = gate_r;
      clear_nxt = clear_r;
      swap_nxt  = swap_r;
      xclk_nxt  = xclk_r;
      cdb_nxt   = cdb_r;
      sb_nxt    = sb_r;
      if (stb_r)
      begin
         // Counter stays at zero while clear is held, else wraps 511 to 0.
         y_nxt     = clear_r ? Y_ZERO : y_r + Y_ONE;
         clear_nxt = (state_r == st_arm) || (state_r == st_swap);
         swap_nxt  = (state_r == st_arm);
         xclk_nxt  = (state_r != st_arm);
         if (state_r == st_arm)
            cdb_nxt = exb_eff;
         if (state_r == st_swap)
            sb_nxt = exb_eff;
         if (state_r == st_wait_lower && match)
         begin
            cdb_nxt = exb_eff;
            sb_nxt  = exb_eff;
         end
         if (state_r == st_wait_retrace && match)
            gate_nxt = 1'b0;
         if (state_r == st_wait_scan && match)
            gate_nxt = 1'b1;
      end
      if (advance)
         state_nxt = step_of(state_r);
   end

   // Test flag and own X blanking drive follow the state being entered.
   always_comb
   begin
      qual_nxt = is_test_state(state_nxt);
      xdrv_nxt = (state_nxt == st_wait_lower);
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_r <= st_arm;
         y_r     <= Y_ZERO;
         gate_r  <= 1'b0;
         clear_r <= 1'b0;
         swap_r  <= 1'b0;
         xclk_r  <= XCLK_RESET;
         cdb_r   <= BLANK_RESET;
         sb_r    <= BLANK_RESET;
         qual_r  <= 1'b0;
         xdrv_r  <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         y_r     <= y_nxt;
         gate_r  <= gate_nxt;
         clear_r <= clear_nxt;
         swap_r  <= swap_nxt;
         xclk_r  <= xclk_nxt;
         cdb_r   <= cdb_nxt;
         sb_r    <= sb_nxt;
         qual_r  <= qual_nxt;
         xdrv_r  <= xdrv_nxt;
      end
   end

   // APB decode: read data and error are set up in the setup cycle for one wait-free access.
   assign setup  = psel && !penable;
   assign mapped = (paddr == CTRL_OFS) || (paddr == STATUS_OFS) || (paddr == MATCH_OFS);

   // Read multiplexer.
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      unique case (paddr)
         CTRL_OFS:
         begin
            rd_mux[CTRL_W-1:0] = ctrl_r;
         end
         STATUS_OFS:
         begin
            rd_mux[ST_STATE_LSB +: 4]      = state_idx;
            rd_mux[ST_GATE_BIT]            = gate_r;
            rd_mux[ST_CDB_BIT]             = cdb_r;
            rd_mux[ST_SB_BIT]              = sb_r;
            rd_mux[ST_CLEAR_BIT]           = clear_r;
            rd_mux[ST_SWAP_BIT]            = swap_r;
            rd_mux[ST_QUAL_BIT]            = qual_r;
            rd_mux[ST_XCLK_BIT]            = xclk_r;
            rd_mux[ST_Y_LSB +: Y_WIDTH]    = y_r;
         end
         MATCH_OFS:
         begin
            rd_mux[Y_WIDTH-1:0] = match_val;
         end
         default:
         begin
            rd_mux = 32'h0000_0000;
         end
      endcase
   end

   // Bus answer and control register write at the access edge.
   always_comb
   begin
      ctrl_nxt    = ctrl_r;
      pready_nxt  = setup;
      pslverr_nxt = setup && !mapped;
      prdata_nxt  = (setup && !pwrite) ? rd_mux : 32'h0000_0000;
      if (psel && penable && pready_r && pwrite && paddr == CTRL_OFS && pstrb[0])
         ctrl_nxt = pwdata[CTRL_W-1:0];
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ctrl_r    <= CTRL_RESET;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0000_0000;
      end
      else
      begin
         ctrl_r    <= ctrl_nxt;
         pready_r  <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         prdata_r  <= prdata_nxt;
      end
   end

   // Outputs come straight from their flip-flops.
   assign prdata                 = prdata_r;
   assign pready                 = pready_r;
   assign pslverr                = pslverr_r;
   assign x_blanking_drive       = xdrv_r;
   assign y_count_enable_a       = stb_r;
   assign y_count                = y_r;
   assign y_ramp_gate            = gate_r;
   assign y_count_clear          = clear_r;
   assign cache_swap_pulse       = swap_r;
   assign x_count_clock          = xclk_r;
   assign composite_buffer_blank = cdb_r;
   assign storage_blank          = sb_r;
   assign qualifier_test         = qual_r;

endmodule // y_ramp_sequencer

// ### verif/y_ramp_sequencer_chk.sv
`timescale 1ns/1ps
// Checks the scan timing relations at the sequencer pins.
module y_ramp_sequencer_chk
   import ysq_pkg::*;
(
   input wire logic       clk,
   input wire logic       rstn,
   input wire logic       x_blanking_enable,
   input wire logic       x_blanking_drive,
   input wire logic       y_count_enable_a,
   input wire logic [8:0] y_count,
   input wire logic       y_ramp_gate,
   input wire logic       y_count_clear,
   input wire logic       cache_swap_pulse,
   input wire logic       x_count_clock,
   input wire logic       composite_buffer_blank,
   input wire logic       storage_blank,
   input wire logic       qualifier_test
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   // Scan start, swap state and blank loading.
   property p_arm;
      $rose(cache_swap_pulse) |-> y_count_clear && !x_count_clock && $past(y_count_enable_a);
   endproperty
   a_arm: assert property (p_arm)
      else $error("swap rose without clear");
   property p_swap;
      cache_swap_pulse && y_count_enable_a |=> !cache_swap_pulse && x_count_clock;
   endproperty
   a_swap: assert property (p_swap)
      else $error("swap or x clock held too long");
   property p_cdb;
      $rose(cache_swap_pulse) |-> composite_buffer_blank == $past(x_blanking_enable);
   endproperty
   a_cdb: assert property (p_cdb)
      else $error("composite blank not loaded");
   property p_sb;
      $fell(cache_swap_pulse) |-> storage_blank == $past(x_blanking_enable);
   endproperty
   a_sb: assert property (p_sb)
      else $error("storage blank not loaded");
   property p_hold;
      $changed({composite_buffer_blank, storage_blank}) |-> $past(y_count_enable_a)
         && ($past(cache_swap_pulse) || $rose(cache_swap_pulse) || $past(x_blanking_drive));
   endproperty
   a_hold: assert property (p_hold)
      else $error("blank changed outside its load");

   // Y counter clearing and stepping.
   property p_clr;
      y_count_clear && y_count_enable_a |=> y_count == Y_ZERO;
   endproperty
   a_clr: assert property (p_clr)
      else $error("y counter not cleared");
   property p_step;
      y_count_enable_a && !y_count_clear |=> y_count == $past(y_count) + Y_ONE;
   endproperty
   a_step: assert property (p_step)
      else $error("y counter step wrong");
   property p_idle;
      !y_count_enable_a |=> $stable(y_count);
   endproperty
   a_idle: assert property (p_idle)
      else $error("y counter moved without enable");

   // Match decisions of the waiting states.
   property p_lower;
      x_blanking_drive && y_count_enable_a |=> (y_count == 9'h1FF)
         == (composite_buffer_blank && storage_blank && !x_blanking_drive);
   endproperty
   a_lower: assert property (p_lower)
      else $error("lower boundary wrong");
   property p_retrace;
      qualifier_test && y_ramp_gate && !x_blanking_drive && y_count_enable_a
         |=> y_ramp_gate == ($past(y_count) != 9'h00B);
   endproperty
   a_retrace: assert property (p_retrace)
      else $error("retrace start wrong");
   property p_scan;
      qualifier_test && !y_ramp_gate && !x_blanking_drive && y_count_enable_a
         |=> y_ramp_gate == ($past(y_count) == 9'h037);
   endproperty
   a_scan: assert property (p_scan)
      else $error("scan start wrong");
   property p_end;
      qualifier_test && y_ramp_gate && !x_blanking_drive && y_count_enable_a
         && y_count == 9'h04F |=> !qualifier_test ##[1:16] $rose(cache_swap_pulse);
   endproperty
   a_end: assert property (p_end)
      else $error("loop end wrong");

   // Main scenarios reached.
   c_swap: cover property ($rose(cache_swap_pulse));
   c_lower: cover property ($fell(x_blanking_drive));
   c_unblank: cover property ($fell(composite_buffer_blank));
endmodule // y_ramp_sequencer_chk

bind y_ramp_sequencer y_ramp_sequencer_chk chk_u (.*);

// ### verif/x_seq_model.sv
`timescale 1ns/1ps
// Far-side X sequencer: blanking moves only as a column is counted.
module x_seq_model
(
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        x_count_clock,
   input  wire logic        blank_req,
   input  wire logic        composite_buffer_blank,
   input  wire logic        buffer_data_active,
   output logic             x_blanking_enable,
   output logic      [15:0] kept_count
);
   logic xclk_r;

   // A rise of the X count clock takes the next column's blanking level.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         xclk_r            <= 1'b1;
         x_blanking_enable <= 1'b1;
         kept_count        <= 16'h0000;
      end
      else
      begin
         xclk_r <= x_count_clock;
         if (x_count_clock && !xclk_r)
            x_blanking_enable <= blank_req;
         // The cache side keeps unblanked data only while buffering runs; idle discards it.
         if (!composite_buffer_blank && buffer_data_active)
            kept_count <= kept_count + 16'h0001;
      end
   end
endmodule // x_seq_model

// ### verif/y_ramp_sequencer_tb.sv
`timescale 1ns/1ps
module y_ramp_sequencer_tb;
   import ysq_pkg::*;
   logic        clk;
   logic        rstn;
   logic [11:0] paddr;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [31:0] pwdata;
   logic [3:0]  pstrb;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        x_blanking_enable;
   logic        x_blanking_drive;
   logic        y_count_enable_a;
   logic [8:0]  y_count;
   logic        y_ramp_gate;
   logic        y_count_clear;
   logic        cache_swap_pulse;
   logic        x_count_clock;
   logic        composite_buffer_blank;
   logic        storage_blank;
   logic        qualifier_test;
   logic        blank_req;
   logic        buffer_data_active;
   logic [15:0] kept_count;
   logic [31:0] rd;
   logic        er;
   int          errors;
   int          n_checks;

   y_ramp_sequencer #(.YCLK_DIV(2)) dut_u (.*);
   x_seq_model model_u (.*);

   // Free-running 125 MHz clock.
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
      n_checks++;
      if (s !== x)
      begin
         errors++;
         $display("Error %s exp %h got %h", nm, x, s);
      end
   endtask

   function automatic logic pick(input int k);
      case (k)
         0: return cache_swap_pulse;
         1: return !cache_swap_pulse;
         2: return x_blanking_drive;
         3: return y_ramp_gate;
         4: return !y_ramp_gate;
         default: return y_count == 9'h1FF;
      endcase
   endfunction

   task automatic wait_rise(input int k);
      int i;
      i = 0;
      while (pick(k) === 1'b1 && i < 4000)
      begin
         @(negedge clk);
         i++;
      end
      while (pick(k) !== 1'b1 && i < 4000)
      begin
         @(negedge clk);
         i++;
      end
      if (i >= 4000)
      begin
         errors++;
         $display("Error wait %0d timed out", k);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int i;
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      i = 0;
      // Ready and data are read on the falling edge, where they stand for the next rising edge.
      do
      begin
         @(negedge clk);
         i++;
      end
      while (pready !== 1'b1 && i < 50);
      q = prdata;
      e = pslverr;
      @(posedge clk);
      psel    <= 1'b0;
      penable <= 1'b0;
      if (i >= 50)
      begin
         errors++;
         $display("Error apb ready missing");
      end
   endtask

   task automatic t_reset;
      @(negedge clk);
      chk("reset outs", 32'({y_ramp_gate, y_count_clear, cache_swap_pulse, x_count_clock,
          composite_buffer_blank, storage_blank, qualifier_test}), 32'h0E);
      @(posedge clk);
      rstn <= 1'b1;
      $display("test reset done");
   endtask

   task automatic t_regs;
      logic [8:0] v;
      apb(1'b0, CTRL_OFS, 32'h0, rd, er);
      chk("ctrl reset", rd, 32'h1);
      pstrb <= 4'h0;
      apb(1'b1, CTRL_OFS, 32'h0, rd, er);
      pstrb <= 4'hF;
      apb(1'b0, CTRL_OFS, 32'h0, rd, er);
      chk("ctrl no strobe", rd, 32'h1);
      apb(1'b1, CTRL_OFS, 32'h0, rd, er);
      repeat (4) @(negedge clk);
      v = y_count;
      repeat (20) @(negedge clk);
      chk("frozen y", 32'(y_count), 32'(v));
      apb(1'b0, STATUS_OFS, 32'h0, rd, er);
      chk("status y", 32'(rd[ST_Y_LSB +: Y_WIDTH]), 32'(v));
      apb(1'b1, CTRL_OFS, 32'h1, rd, er);
      apb(1'b0, 12'h00C, 32'h0, rd, er);
      chk("unmapped", {er, rd[30:0]}, 32'h80000000);
      apb(1'b1, STATUS_OFS, 32'hFFFFFFFF, rd, er);
      chk("status write", 32'(er), 32'h0);
      $display("test regs done");
   endtask

   task automatic t_scan(input logic b);
      int          n;
      logic [15:0] k0;
      k0 = kept_count;
      blank_req          <= b;
      buffer_data_active <= !b;
      wait_rise(0);
      wait_rise(0);
      chk("arm", 32'({y_count_clear, x_count_clock, composite_buffer_blank}), 32'({2'b10, b}));
      chk("arm y", 32'(y_count), 32'h51);
      wait_rise(1);
      chk("swap end", 32'({storage_blank, y_count_clear, y_count}), 32'({b, 10'h200}));
      n = 0;
      while (!x_blanking_drive && n < 20)
      begin
         @(negedge clk);
         n += int'(y_count_enable_a);
      end
      chk("fillers", 32'(n), 32'h7);
      wait_rise(5);
      chk("lower", 32'({composite_buffer_blank, storage_blank, x_blanking_drive}), 32'h6);
      chk("kept", 32'(kept_count != k0), 32'(!b));
      wait_rise(4);
      chk("retrace y", 32'(y_count), 32'h0C);
      wait_rise(3);
      chk("scan y", 32'(y_count), 32'h38);
      $display("test scan done");
   endtask

   task automatic t_opts;
      logic [7:0] m;
      wait_rise(2);
      for (int v = 3; v < 10; v += 2)
      begin
         apb(1'b1, CTRL_OFS, 32'(v % 8), rd, er);
         apb(1'b0, MATCH_OFS, 32'h0, rd, er);
         m = MATCH_VALS[{~v[2], v[1]}][0];
         chk("match", rd, 32'({m[7:4], m[4:0]}));
      end
      $display("test options done");
   endtask

   task automatic test_done;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Main sequence.
   initial
   begin
      errors = 0;
      n_checks = 0;
      rstn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'hF;
      blank_req = 1'b1;
      buffer_data_active = 1'b0;
      repeat (16) @(posedge clk);
      t_reset;
      t_regs;
      t_scan(1'b0);
      t_scan(1'b1);
      t_opts;
      test_done;
   end

   // Watchdog well beyond the expected run of about 6000 cycles.
   initial
   begin
      repeat (40000) @(posedge clk);
      errors++;
      $display("Error watchdog expired");
      test_done;
   end
endmodule // y_ramp_sequencer_tb
